// *** pkg/sspi_regs.vh ***
// Summary of operation
// - Buffer write during a transfer is ignored and sets sticky write collision flag.
// - Slave byte arriving while buffer unread sets overflow and is discarded.
// - Master mode never sets the receive overflow flag.
// - Port enable hands clock and data pins to the port, else general I/O.
// - Clock idle polarity sets the serial clock idle level.
// - Codes 0000-0011 select master at osc/4, /16, /64 or timer2/2.
// - Code 0100 is slave with select; 0101 slave ignoring select.
// - Eight bits exchanged full duplex through one shift register, MSB first.
// - Completed byte moves to buffer, setting buffer full and interrupt flags.
// - Reading the buffer clears the buffer full flag.
// - Master starts shifting and clocking as soon as the buffer is written.
// - Shift register is reached only through buffer accesses.
// - Drive data on the programmed edge, capture on the opposite; same polarity.
// - Master keeps shifting with its clock pin made an input.
// - Slave shifts on external clock edges, flags interrupt on last bit.
// - Slave keeps working in sleep and can wake the device per byte.
// - Slave with select control drives data out only while select is low.
// - Select returning low resumes the byte at the stopped bit position.
// - Slave with select control freezes its logic while select is high, keeping its bit position.
// - Edge select picks transmit edge, relative to clock idle polarity.
// - Master sample phase picks middle or end sampling; clear in slave.
`ifndef SSPI_REGS_VH
`define SSPI_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SSPI_IDX_IRQ 10'h00c
`define SSPI_IDX_BUF 10'h013
`define SSPI_IDX_CTRL 10'h014
`define SSPI_IDX_STAT 10'h094

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define SSPI_CTRL_RST 8'h00
`define SSPI_STAT_RST 8'h00
`define SSPI_CTRL_WRITE_COLLISION_FLAG 7
`define SSPI_CTRL_OV 6
`define SSPI_CTRL_EN 5
`define SSPI_CTRL_CKP 4
`define SSPI_STAT_SMP 7
`define SSPI_STAT_CKE 6
`define SSPI_STAT_BF 0
`define SSPI_IRQ_FLAG 3
`define SSPI_DIR_SCK 3
`define SSPI_DIR_SDO 5

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define SSPI_MODE_M4 4'h0
`define SSPI_MODE_M16 4'h1
`define SSPI_MODE_M64 4'h2
`define SSPI_MODE_MT2 4'h3
`define SSPI_MODE_SLV_SS 4'h4
`define SSPI_MODE_SLV_NOSS 4'h5

// ----------------------------------------
// Timing counts: half periods in clk_sys cycles, then last bit and last edge indices
// ----------------------------------------
`define SSPI_HALF_DIV4 6'h02
`define SSPI_HALF_DIV16 6'h08
`define SSPI_HALF_DIV64 6'h20
`define SSPI_LAST_BIT 3'h7
`define SSPI_LAST_EDGE 4'hf

`endif

// *** core/sspi_sync2.v ***
`timescale 1ns/1ns
`default_nettype none
module sspi_sync2 #(
	parameter W = 3
) (
	input wire clk_sys,
	input wire srst,
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // sspi_sync2
`default_nettype wire

// *** core/sspi_clkgen.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sspi_regs.vh"
module sspi_clkgen (
	input wire clk_sys,
	input wire srst,
	input wire run,
	input wire [1:0] rate,
	input wire timer2_tick,
	output wire tick
);
	reg [5:0] cnt_q;
	reg [5:0] half;
	wire use_t2;
	wire hit;

	// Half period of the bit clock; timer2 ticks halve the timer rate
	always @* begin
		case (rate)
			2'h0: half = `SSPI_HALF_DIV4;
			2'h1: half = `SSPI_HALF_DIV16;
			default: half = `SSPI_HALF_DIV64;
		endcase
	end

	assign use_t2 = (rate == 2'h3);
	assign hit = use_t2 ? timer2_tick : (cnt_q == half - 6'h01);

	always @(posedge clk_sys) begin
		if (srst | ~run | hit) begin
			cnt_q <= 6'h00;
		end else if (~use_t2) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	assign tick = run & hit;
endmodule // sspi_clkgen
`default_nettype wire

// *** core/sspi_top.v ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sspi_regs.vh"
module sspi_top (
	input wire clk_sys,
	input wire srst,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire timer2_output,
	input wire [7:0] portc_direction,
	input wire porta_direction_ss,
	input wire sck_in,
	output wire sck_out,
	output wire sck_oe_n,
	input wire serial_data_in,
	output wire serial_data_out,
	output wire sdo_oe_n,
	input wire ss_n_in,
	input wire gpio_sck_out,
	input wire gpio_sck_oe_n,
	input wire gpio_sdo_out,
	input wire gpio_sdo_oe_n,
	output wire port_irq,
	output wire wake_req
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_LATE = 3'b100;
	localparam [7:0] STAT_RST = `SSPI_STAT_RST;

	reg write_collision_flag_q;
	reg receive_overflow_flag_q;
	reg port_enable_q;
	reg clock_idle_polarity_q;
	reg [3:0] mode_select_q;
	reg input_sample_phase_q;
	reg clock_edge_q;
	reg buffer_full_flag_q;
	reg port_interrupt_flag_q;
	reg [7:0] serial_buffer_q;
	reg [7:0] shift_register_q;
	reg sdo_q;
	reg sck_q;
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [3:0] edge_q;
	reg [2:0] bit_q;
	reg pend_q;
	reg act_q;
	reg sck_d_q;
	reg wake_q;
	reg [1:0] smp_dly_q;

	wire [2:0] sync_out;
	wire sck_s;
	wire sdi_s;
	wire ss_n_s;
	wire m_tick;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function hit_idx;
		input [11:0] addr;
		input [9:0] idx;
		begin
			hit_idx = (addr[11:2] == idx);
		end
	endfunction

	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire a_irq = hit_idx(paddr, `SSPI_IDX_IRQ);
	wire a_buf = hit_idx(paddr, `SSPI_IDX_BUF);
	wire a_ctrl = hit_idx(paddr, `SSPI_IDX_CTRL);
	wire a_stat = hit_idx(paddr, `SSPI_IDX_STAT);
	wire mapped = a_irq | a_buf | a_ctrl | a_stat;

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire mode_ok = (mode_select_q <= `SSPI_MODE_SLV_NOSS);
	wire spi_on = port_enable_q & mode_ok;
	wire is_master = port_enable_q & (mode_select_q <= `SSPI_MODE_MT2);
	wire is_slave = spi_on & ~is_master;
	wire ss_ctl = is_slave & (mode_select_q == `SSPI_MODE_SLV_SS) & porta_direction_ss;
	// Select high freezes the slave: outputs released, position kept
	wire ss_hold = ss_ctl & ss_n_s;
	// Transmit edge direction from edge select and idle polarity
	wire tx_on_rise = clock_edge_q ^ clock_idle_polarity_q;
	// Late sampling is a master-only option
	wire smp_late = is_master & input_sample_phase_q;

	// ----------------------------------------
	// Pin synchronisers and master bit clock
	// ----------------------------------------
	sspi_sync2 #(
		.W(3)
	) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in({sck_in, serial_data_in, ss_n_in}),
		.sync_out(sync_out)
	);

	assign sck_s = sync_out[2];
	assign sdi_s = sync_out[1];
	assign ss_n_s = sync_out[0];

	sspi_clkgen u_clkgen (
		.clk_sys(clk_sys),
		.srst(srst),
		.run(st_q != ST_IDLE),
		.rate(mode_select_q[1:0]),
		.timer2_tick(timer2_output),
		.tick(m_tick)
	);

	// ----------------------------------------
	// Shared edge events
	// ----------------------------------------
	wire m_edge = (st_q == ST_RUN) & m_tick;
	wire s_edge = is_slave & ~ss_hold & (sck_s ^ sck_d_q);
	wire ev = m_edge | s_edge;
	wire ev_rise = is_master ? ~sck_q : sck_s;
	wire ev_tx = ev & (ev_rise == tx_on_rise);
	wire ev_smp = ev & ~ev_tx;
	// A late sample lands on the next half-period boundary
	wire late_go = pend_q & m_tick;
	// Master mid samples wait out the data-in synchroniser, else the fast rate reads the old bit
	wire mid_go = ev_smp & ~smp_late & is_master;
	wire do_shift = (ev_smp & ~smp_late & ~is_master) | smp_dly_q[1] | late_go;
	wire done = do_shift & (bit_q == `SSPI_LAST_BIT);
	wire [7:0] shifted = {shift_register_q[6:0], sdi_s};

	// ----------------------------------------
	// Buffer write acceptance
	// ----------------------------------------
	wire busy = (st_q != ST_IDLE) | (is_slave & act_q);
	wire buf_wr = wr & a_buf;
	wire buf_ok = buf_wr & ~busy;
	wire buf_col = buf_wr & busy;
	wire buf_rd = rd & a_buf;
	wire ovf = done & is_slave & buffer_full_flag_q;

	// ----------------------------------------
	// Master sequencing
	// ----------------------------------------
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (buf_ok & is_master) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (m_edge & (edge_q == `SSPI_LAST_EDGE)) begin
					st_d = (smp_late & ev_smp) ? ST_LATE : ST_IDLE;
				end
			end
			ST_LATE: begin
				if (m_tick) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (srst | ~is_master) begin
			st_q <= ST_IDLE;
			edge_q <= 4'h0;
			sck_q <= clock_idle_polarity_q;
		end else begin
			st_q <= st_d;
			if (st_q == ST_IDLE) begin
				edge_q <= 4'h0;
				sck_q <= clock_idle_polarity_q;
			end else if (m_edge) begin
				edge_q <= edge_q + 4'h1;
				sck_q <= ~sck_q;
			end
		end
	end

	// ----------------------------------------
	// Shift engine, both modes
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			bit_q <= 3'h0;
			pend_q <= 1'b0;
			act_q <= 1'b0;
			sck_d_q <= 1'b0;
			smp_dly_q <= 2'b00;
		end else begin
			sck_d_q <= sck_s;
			if (~spi_on) begin
				bit_q <= 3'h0;
				pend_q <= 1'b0;
				act_q <= 1'b0;
				smp_dly_q <= 2'b00;
			end else begin
				smp_dly_q <= {smp_dly_q[0], mid_go};
				// Counters survive a select pause so the byte resumes
				if (do_shift) begin
					bit_q <= bit_q + 3'h1;
				end
				if (ev_smp & smp_late) begin
					pend_q <= 1'b1;
				end else if (late_go) begin
					pend_q <= 1'b0;
				end
				if (done) begin
					act_q <= 1'b0;
				end else if (s_edge & (ev_smp | clock_edge_q)) begin
					act_q <= 1'b1;
				end
			end
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			shift_register_q <= 8'h00;
			sdo_q <= 1'b0;
		end else if (buf_ok) begin
			shift_register_q <= pwdata[7:0];
			if (~clock_edge_q) begin
				sdo_q <= pwdata[7];
			end
		end else begin
			if (do_shift) begin
				shift_register_q <= shifted;
			end
			if (ev_tx) begin
				sdo_q <= do_shift ? shift_register_q[6] : shift_register_q[7];
			end
		end
	end

	// ----------------------------------------
	// Serial buffer and flags
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			serial_buffer_q <= 8'h00;
			buffer_full_flag_q <= 1'b0;
			port_interrupt_flag_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			wake_q <= done & is_slave;
			if (done & ~ovf) begin
				serial_buffer_q <= shifted;
			end else if (buf_ok) begin
				serial_buffer_q <= pwdata[7:0];
			end
			// Set wins over a same-cycle read
			if (done & ~ovf) begin
				buffer_full_flag_q <= 1'b1;
			end else if (buf_rd) begin
				buffer_full_flag_q <= 1'b0;
			end
			if (done) begin
				port_interrupt_flag_q <= 1'b1;
			end else if (wr & a_irq) begin
				port_interrupt_flag_q <= pwdata[`SSPI_IRQ_FLAG];
			end
		end
	end

	// ----------------------------------------
	// Control and status registers
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			{write_collision_flag_q, receive_overflow_flag_q, port_enable_q,
				clock_idle_polarity_q, mode_select_q} <= `SSPI_CTRL_RST;
			{input_sample_phase_q, clock_edge_q} <= STAT_RST[`SSPI_STAT_SMP:`SSPI_STAT_CKE];
		end else begin
			if (wr & a_ctrl) begin
				port_enable_q <= pwdata[`SSPI_CTRL_EN];
				clock_idle_polarity_q <= pwdata[`SSPI_CTRL_CKP];
				mode_select_q <= pwdata[3:0];
			end
			// Hardware set wins over a software clear in the same cycle
			if (buf_col) begin
				write_collision_flag_q <= 1'b1;
			end else if (wr & a_ctrl) begin
				write_collision_flag_q <= pwdata[`SSPI_CTRL_WRITE_COLLISION_FLAG];
			end
			if (ovf) begin
				receive_overflow_flag_q <= 1'b1;
			end else if (wr & a_ctrl) begin
				receive_overflow_flag_q <= pwdata[`SSPI_CTRL_OV];
			end
			if (wr & a_stat) begin
				input_sample_phase_q <= pwdata[`SSPI_STAT_SMP];
				clock_edge_q <= pwdata[`SSPI_STAT_CKE];
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		prdata = 32'h00000000;
		if (a_ctrl) begin
			prdata[7:0] = {write_collision_flag_q, receive_overflow_flag_q, port_enable_q,
				clock_idle_polarity_q, mode_select_q};
		end else if (a_stat) begin
			prdata[7:0] = {input_sample_phase_q, clock_edge_q, 5'h00, buffer_full_flag_q};
		end else if (a_buf) begin
			prdata[7:0] = serial_buffer_q;
		end else if (a_irq) begin
			prdata[`SSPI_IRQ_FLAG] = port_interrupt_flag_q;
		end
	end

	// ----------------------------------------
	// Pin muxing
	// ----------------------------------------
	// Enabled with a foreign mode code floats both pins rather than guess
	wire sck_drv = is_master & ~portc_direction[`SSPI_DIR_SCK];
	wire sdo_drv = ~portc_direction[`SSPI_DIR_SDO] & (is_master | (is_slave & ~ss_hold));

	assign sck_out = port_enable_q ? sck_q : gpio_sck_out;
	assign sck_oe_n = port_enable_q ? ~(spi_on & sck_drv) : gpio_sck_oe_n;
	assign serial_data_out = port_enable_q ? sdo_q : gpio_sdo_out;
	assign sdo_oe_n = port_enable_q ? ~(spi_on & sdo_drv) : gpio_sdo_oe_n;
	assign port_irq = port_interrupt_flag_q;
	assign wake_req = wake_q;
endmodule // sspi_top
`default_nettype wire

// *** tb/sspi_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sspi_regs.vh"
module sspi_checker (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic [7:0] portc_direction,
	input wire logic porta_direction_ss,
	input wire logic ss_n_in,
	input wire logic sck_out,
	input wire logic sck_oe_n,
	input wire logic sdo_oe_n,
	input wire logic gpio_sck_out,
	input wire logic gpio_sck_oe_n,
	input wire logic port_irq,
	input wire logic wake_req
);
	// ----------------
	// Software view of control, aged so that pins may settle
	// ----------------
	logic [5:0] ctl_q;
	logic [5:0] age_q;
	logic [5:0] still_q;
	logic [3:0] ss_q;
	wire wr_ctl = psel && penable && pwrite && paddr == {`SSPI_IDX_CTRL, 2'b00};
	wire ok = ctl_q[5] && age_q > 6'h03;
	wire [3:0] md = ctl_q[3:0];
	always @(posedge clk_sys) begin
		if (srst) begin
			ctl_q <= 6'h00;
			ss_q <= 4'h0;
		end else begin
			ss_q <= {ss_q[2:0], ss_n_in};
			if (wr_ctl) begin
				ctl_q <= pwdata[5:0];
			end
		end
		if (srst || wr_ctl || $changed(portc_direction)) begin
			age_q <= 6'h00;
		end else if (age_q != 6'h3f) begin
			age_q <= age_q + 6'h01;
		end
		if (srst || wr_ctl || $changed(sck_out)) begin
			still_q <= 6'h00;
		end else if (still_q != 6'h3f) begin
			still_q <= still_q + 6'h01;
		end
	end
	// ----------------
	// Assertions
	// ----------------
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_gpio_when_off: assert property (!ctl_q[5] && age_q > 6'h03 && $stable(gpio_sck_out) && $stable(gpio_sck_oe_n)
		|-> sck_out == gpio_sck_out && sck_oe_n == gpio_sck_oe_n) else $error("sck pin not released");
	a_bad_mode_float: assert property (ok && md > 4'h5 |-> sck_oe_n && sdo_oe_n) else $error("pins driven");
	a_slave_clk_in: assert property (ok && (md == 4'h4 || md == 4'h5) |-> sck_oe_n) else $error("slave drives sck");
	a_master_clk_out: assert property (ok && md < 4'h4 |-> sck_oe_n == portc_direction[3])
		else $error("master sck enable wrong");
	a_fast_half: assert property (ok && md == 4'h0 && $changed(sck_out) |=> $stable(sck_out))
		else $error("fast half period short");
	a_mid_half: assert property (ok && md == 4'h1 && $changed(sck_out) |=> $stable(sck_out) [*7])
		else $error("mid half period short");
	a_idle_level: assert property (ok && md < 4'h3 && still_q > 6'h28 |-> sck_out == ctl_q[4])
		else $error("sck idle level wrong");
	a_select_float: assert property (ok && md == 4'h4 && porta_direction_ss && ss_q == 4'hf |-> sdo_oe_n)
		else $error("sdo driven while deselected");
	a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake not a pulse");
	a_wake_irq: assert property (wake_req |-> port_irq) else $error("wake without irq");
	a_err_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
	cover property (wake_req);
	cover property (ok && md == 4'h1 && $changed(sck_out));
	cover property (pslverr);
endmodule // sspi_checker
bind sspi_top sspi_checker u_chk (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr), .portc_direction(portc_direction),
	.porta_direction_ss(porta_direction_ss), .ss_n_in(ss_n_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
	.sdo_oe_n(sdo_oe_n), .gpio_sck_out(gpio_sck_out), .gpio_sck_oe_n(gpio_sck_oe_n), .port_irq(port_irq),
	.wake_req(wake_req));
`default_nettype wire

// *** tb/sspi_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module sspi_peer (
	input wire logic clk_sys,
	input wire logic sck,
	input wire logic din,
	output logic dout,
	output logic sck_drv,
	output logic ss_n
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rx = 8'h00;
	assign dout = sh[7];
	initial begin
		sck_drv = 1'b0;
		ss_n = 1'b1;
	end
	// Idle-low clock, edge select 0: capture on rising, next bit on falling
	always @(posedge sck) rx <= {rx[6:0], din};
	always @(negedge sck) sh <= {sh[6:0], 1'b0};
	// Acting as master; the clock stands still outside the frame
	task automatic xfer(input logic [7:0] b, input int half);
		sh = b;
		ss_n <= 1'b0;
		repeat (8) begin
			repeat (half) @(posedge clk_sys);
			sck_drv <= 1'b1;
			repeat (half) @(posedge clk_sys);
			sck_drv <= 1'b0;
		end
		repeat (half) @(posedge clk_sys);
		ss_n <= 1'b1;
	endtask
endmodule // sspi_peer
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sspi_regs.vh"
module testbench;
	localparam logic [11:0] A_BUF = {`SSPI_IDX_BUF, 2'b00};
	localparam logic [11:0] A_CTL = {`SSPI_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_STA = {`SSPI_IDX_STAT, 2'b00};
	localparam logic [11:0] A_IRQ = {`SSPI_IDX_IRQ, 2'b00};
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic timer2_output = 1'b0;
	logic [7:0] portc_direction = 8'h00;
	logic porta_direction_ss = 1'b1;
	logic [3:0] gpio = 4'h0;
	logic tgl = 1'b0;
	logic wk = 1'b0;
	logic [7:0] sta_w = 8'h00;
	logic [15:0] seed = 16'h002d;
	logic [32:0] expq[$];
	int fail_count = 0;
	int num_checks = 0;
	wire [31:0] prdata;
	wire pready, pslverr, sck_out, sck_oe_n, serial_data_out, sdo_oe_n, port_irq, wake_req;
	wire sck_pin, sdo_pin, peer_dout, peer_sck, peer_ss_n;
	// Released data line shows a changing pattern, never a held value
	assign sck_pin = sck_oe_n ? peer_sck : sck_out;
	assign sdo_pin = sdo_oe_n ? tgl : serial_data_out;
	sspi_top u_dut (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer2_output(timer2_output),
		.portc_direction(portc_direction), .porta_direction_ss(porta_direction_ss), .sck_in(sck_pin),
		.sck_out(sck_out), .sck_oe_n(sck_oe_n), .serial_data_in(peer_dout), .serial_data_out(serial_data_out),
		.sdo_oe_n(sdo_oe_n), .ss_n_in(peer_ss_n), .gpio_sck_out(gpio[0]), .gpio_sck_oe_n(gpio[1]),
		.gpio_sdo_out(gpio[2]), .gpio_sdo_oe_n(gpio[3]), .port_irq(port_irq), .wake_req(wake_req));
	sspi_peer u_peer (.clk_sys(clk_sys), .sck(sck_pin), .din(sdo_pin), .dout(peer_dout), .sck_drv(peer_sck),
		.ss_n(peer_ss_n));
	initial forever #20 clk_sys = ~clk_sys;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// ----------------
	// Free-running stimulus and read monitor
	// ----------------
	always @(posedge clk_sys) begin
		seed <= lfsr(seed);
		// Clock pin stays released to the peer while the port is off; a stray level reads as a slave edge
		gpio <= {seed[3:2], 1'b1, seed[0]};
		tgl <= ~tgl;
		timer2_output <= seed[0] & ~timer2_output;
		if (wake_req === 1'b1) begin
			wk <= 1'b1;
		end
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
			check({pslverr, prdata}, expq.pop_front());
		end
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 64) begin
			@(posedge clk_sys);
			n++;
		end
		if (pready !== 1'b1) begin
			fail_count++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic e);
		expq.push_back({e, 24'h0, d});
		apb(1'b0, a, 8'h00);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (port_irq !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		check({32'h0, port_irq}, 33'h1);
		apb(1'b1, A_IRQ, 8'h00);
	endtask
	task automatic mx(input logic [3:0] m);
		logic [7:0] a;
		logic [7:0] b;
		a = seed[11:4];
		b = seed[15:8];
		apb(1'b1, A_CTL, {4'h0, m});
		apb(1'b1, A_CTL, {4'h2, m});
		u_peer.sh = b;
		apb(1'b1, A_BUF, a);
		if (m == 4'h2) apb(1'b1, A_BUF, ~a);
		wait_irq;
		check({25'h0, u_peer.rx}, {25'h0, a});
		rd(A_CTL, {m == 4'h2, 3'h2, m}, 1'b0);
		rd(A_STA, sta_w | 8'h01, 1'b0);
		rd(A_BUF, b, 1'b0);
		rd(A_STA, sta_w, 1'b0);
	endtask
	task automatic sx(input logic [3:0] m);
		logic [7:0] a;
		logic [7:0] b;
		a = seed[11:4];
		b = seed[15:8];
		apb(1'b1, A_CTL, {4'h0, m});
		apb(1'b1, A_STA, 8'h00);
		apb(1'b1, A_CTL, {4'h2, m});
		repeat (8) @(posedge clk_sys);
		check({32'h0, sdo_oe_n}, {32'h0, m == 4'h4});
		apb(1'b1, A_BUF, a);
		u_peer.xfer(b, 6);
		wait_irq;
		check({25'h0, u_peer.rx}, {25'h0, a});
		rd(A_BUF, b, 1'b0);
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(A_CTL, 8'h00, 1'b0);
		rd(A_STA, 8'h00, 1'b0);
		rd(12'h100, 8'h00, 1'b1);
		sta_w = 8'h80;
		apb(1'b1, A_STA, sta_w);
		mx(4'h1);
		sta_w = 8'h00;
		apb(1'b1, A_STA, sta_w);
		for (int i = 3; i >= 0; i--) mx(i[3:0]);
		portc_direction <= 8'h08;
		u_peer.sh = 8'hff;
		apb(1'b1, A_BUF, 8'h3c);
		wait_irq;
		rd(A_BUF, 8'hff, 1'b0);
		portc_direction <= 8'h00;
		apb(1'b1, A_BUF, 8'h5a);
		wait_irq;
		apb(1'b1, A_BUF, 8'ha5);
		wait_irq;
		rd(A_CTL, 8'h20, 1'b0);
		rd(A_BUF, 8'h00, 1'b0);
		apb(1'b1, A_CTL, 8'h10);
		apb(1'b1, A_CTL, 8'h30);
		repeat (50) @(posedge clk_sys);
		check({32'h0, sck_out}, 33'h1);
		apb(1'b1, A_CTL, 8'h06);
		apb(1'b1, A_CTL, 8'h26);
		repeat (4) @(posedge clk_sys);
		check({31'h0, sck_oe_n, sdo_oe_n}, 33'h3);
		sx(4'h4);
		sx(4'h5);
		check({32'h0, wk}, 33'h1);
		u_peer.xfer(8'hc3, 6);
		u_peer.xfer(8'h96, 6);
		rd(A_CTL, 8'h65, 1'b0);
		rd(A_BUF, 8'hc3, 1'b0);
		tally_and_finish;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
